// ### icr_map.vh
// Register offsets, field positions, reset values and timing counts for the I2C config target
`ifndef ICR_MAP_VH
`define ICR_MAP_VH

`define ICR_DEV_ADDR 7'h41
`define ICR_ADDR_REV 5'h00
`define ICR_ADDR_SRC 5'h01
`define ICR_ADDR_LOWB 5'h02
`define ICR_ADDR_FULLB 5'h03
`define ICR_ADDR_COLD 5'h04
`define ICR_ADDR_HOT 5'h05
`define ICR_ADDR_PWR 5'h06
`define ICR_ADDR_DOZE 5'h07
`define ICR_ADDR_ADC 5'h08
`define ICR_ADDR_METER 5'h09
`define ICR_ADDR_EN 5'h0A
`define ICR_ADDR_CTRL 5'h0B
`define ICR_ADDR_FLG 5'h0C
`define ICR_ADDR_LIVE 5'h0D
`define ICR_ADDR_PM0 5'h0E
`define ICR_ADDR_PM1 5'h0F
`define ICR_ADDR_PM2 5'h10
`define ICR_ADDR_THERM 5'h11
`define ICR_ADDR_BATT 5'h12
`define ICR_ADDR_SPARE 5'h13

`define ICR_RST_SRC 7'h77
`define ICR_RST_LOWB 6'h2D
`define ICR_RST_FULLB 6'h33
`define ICR_RST_COLD 8'h8F
`define ICR_RST_HOT 8'h2F
`define ICR_RST_PWR 4'h7
`define ICR_RST_DOZE 4'h1
`define ICR_RST_ADC 3'h0
`define ICR_RST_METER 4'h0
`define ICR_RST_EN 6'h01

`define ICR_SRC_LOW_LIMIT 7'h0D
`define ICR_SRC_SLEEP_CODE 7'h0C
`define ICR_BIT_COMMIT 0
`define ICR_BIT_SYNC 2
`define ICR_EVT_READY 0

// Shortest SCL high/low at 1 MHz is 260 ns; the sync unit lags a few cycles
`define ICR_SYNC_BUSY_CYCLES 4'h8

`endif

// ### icr_sync.v
// Two-flop synchroniser with edge and condition detection for the I2C pins
`timescale 1ns/1ps
`default_nettype none
module icr_sync (
    input wire clk,
    input wire rst_n,
    input wire scl_in,
    input wire sda_in,
    output reg scl_s,
    output reg sda_s,
    output reg scl_rise,
    output reg scl_fall,
    output reg start_det,
    output reg stop_det
);
    reg [1:0] scl_meta;
    reg [1:0] sda_meta;
    // ----------------------------------------
    // Sampling
    // ----------------------------------------
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            scl_meta <= 2'h3;
            sda_meta <= 2'h3;
            scl_s <= 1'b1;
            sda_s <= 1'b1;
            scl_rise <= 1'b0;
            scl_fall <= 1'b0;
            start_det <= 1'b0;
            stop_det <= 1'b0;
        end
        else
        begin
            scl_meta <= {scl_meta[0], scl_in};
            sda_meta <= {sda_meta[0], sda_in};
            scl_s <= scl_meta[1];
            sda_s <= sda_meta[1];
            scl_rise <= !scl_s && scl_meta[1];
            scl_fall <= scl_s && !scl_meta[1];
            start_det <= scl_s && scl_meta[1] && sda_s && !sda_meta[1];
            stop_det <= scl_s && scl_meta[1] && !sda_s && sda_meta[1];
        end
    end
endmodule
`default_nettype wire

// ### icr_target.v
// I2C configuration target with register file
// Operation
// - Answer only 7-bit address 0x41; ignore other addresses.
// - Address LSB 1 means master reads, 0 means master writes.
// - Acknowledge matching address by pulling SDA low in ack slot.
// - Works at 100 kHz, 400 kHz and 1 MHz SCL.
// - All bytes shift most significant bit first.
// - Lines are open drain; parties only pull low or release.
// - Start is SDA fall with SCL high; stop is SDA rise.
// - Write: first byte is pointer, next is data; ack every byte.
// - Further write bytes go to consecutive registers; pointer advances.
// - Read: pointer write, repeated start, read address, then data out.
// - Master ack on read advances pointer and sends next register.
// - Register 0 is read-only revision, major [7:4], minor [3:0].
// - Source target is 7 bits at 0x01, reset 0x77.
// - Source code below 0x0D counts as source low.
// - Source code 0b0001100 with doze enable enters sleep.
// - Low battery limit at 0x02, 6 bits, reset 0x2D.
// - Full battery limit at 0x03, 6 bits, reset 0x33.
// - Control 0x0B bit0 commit read-write, bit2 sync busy read-only.
// - Enables at 0x0A, one per event; only ready resets to one.
// - Flags at 0x0C, read-only, same positions, reset zero.
// - Commit set selects register configuration; clear returns to pins.
// - All registers return to defaults on reset.
`timescale 1ns/1ps
`default_nettype none
`include "icr_map.vh"
module icr_target #(
    parameter [3:0] REV_MAJOR = 4'h0, // Arbitrary value
    parameter [3:0] REV_MINOR = 4'h0 // Arbitrary value
) (
    input wire clk,
    input wire rst_n,
    input wire scl_in,
    input wire sda_in,
    output reg sda_out,
    output reg sda_oe,
    input wire [5:0] event_pulse,
    input wire [7:0] live_in,
    input wire [23:0] meter_in,
    input wire [7:0] therm_in,
    input wire [7:0] batt_in,
    output reg use_registers,
    output reg source_low,
    output reg sleep_req,
    output reg [6:0] source_regulation_target,
    output reg [5:0] low_battery_limit,
    output reg [5:0] full_battery_limit,
    output reg [7:0] cold_limit,
    output reg [7:0] hot_limit,
    output reg [3:0] power_options,
    output reg [3:0] doze_control,
    output reg [2:0] battery_adc_rate,
    output reg [3:0] power_meter_control,
    output reg [5:0] event_enables,
    output reg [5:0] event_flags,
    output reg irq
);
    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_ADDR = 3'h1;
    localparam [2:0] ST_ACK = 3'h2;
    localparam [2:0] ST_WRX = 3'h3;
    localparam [2:0] ST_RTX = 3'h4;
    localparam [2:0] ST_RACK = 3'h5;

    wire scl_s;
    wire sda_s;
    wire scl_rise;
    wire scl_fall;
    wire start_det;
    wire stop_det;

    reg [2:0] state_reg;
    reg [3:0] bit_cnt_reg;
    reg [7:0] shift_reg;
    reg [4:0] ptr_reg;
    reg ptr_loaded_reg;
    reg reading_reg;
    reg ack_drive_reg;
    reg commit_reg;
    reg [3:0] sync_cnt_reg;
    reg ready_seen_reg;
    reg [7:0] rd_data;

    icr_sync u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .scl_s(scl_s),
        .sda_s(sda_s),
        .scl_rise(scl_rise),
        .scl_fall(scl_fall),
        .start_det(start_det),
        .stop_det(stop_det)
    );

    // ----------------------------------------
    // Register read mux
    // ----------------------------------------
    function [7:0] reg_read;
        input [4:0] a;
        begin
            case (a)
                `ICR_ADDR_REV: reg_read = {REV_MAJOR, REV_MINOR};
                `ICR_ADDR_SRC: reg_read = {1'b0, source_regulation_target};
                `ICR_ADDR_LOWB: reg_read = {2'h0, low_battery_limit};
                `ICR_ADDR_FULLB: reg_read = {2'h0, full_battery_limit};
                `ICR_ADDR_COLD: reg_read = cold_limit;
                `ICR_ADDR_HOT: reg_read = hot_limit;
                `ICR_ADDR_PWR: reg_read = {4'h0, power_options};
                `ICR_ADDR_DOZE: reg_read = {4'h0, doze_control};
                `ICR_ADDR_ADC: reg_read = {5'h00, battery_adc_rate};
                `ICR_ADDR_METER: reg_read = {4'h0, power_meter_control};
                `ICR_ADDR_EN: reg_read = {2'h0, event_enables};
                `ICR_ADDR_CTRL: reg_read = {5'h00, (sync_cnt_reg != 4'h0), 1'b0, commit_reg};
                `ICR_ADDR_FLG: reg_read = {2'h0, event_flags};
                `ICR_ADDR_LIVE: reg_read = live_in;
                `ICR_ADDR_PM0: reg_read = meter_in[7:0];
                `ICR_ADDR_PM1: reg_read = meter_in[15:8];
                `ICR_ADDR_PM2: reg_read = meter_in[23:16];
                `ICR_ADDR_THERM: reg_read = therm_in;
                `ICR_ADDR_BATT: reg_read = batt_in;
                default: reg_read = 8'h00;
            endcase
        end
    endfunction

    always @*
    begin
        rd_data = reg_read(ptr_reg);
    end

    // ----------------------------------------
    // Serial protocol engine
    // ----------------------------------------
    // SDA changes only right after an SCL fall, so it is stable while SCL is high
    wire wr_strobe = (state_reg == ST_WRX) && scl_fall && (bit_cnt_reg == 4'h8)
        && ptr_loaded_reg;

    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_reg <= ST_IDLE;
            bit_cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            ptr_reg <= 5'h00;
            ptr_loaded_reg <= 1'b0;
            reading_reg <= 1'b0;
            ack_drive_reg <= 1'b0;
            sda_out <= 1'b0;
            sda_oe <= 1'b0;
        end
        else if (stop_det)
        begin
            state_reg <= ST_IDLE;
            sda_oe <= 1'b0;
        end
        else if (start_det)
        begin
            state_reg <= ST_ADDR;
            bit_cnt_reg <= 4'h0;
            sda_oe <= 1'b0;
        end
        else
        begin
            sda_out <= 1'b0;
            case (state_reg)
                ST_ADDR, ST_WRX:
                begin
                    if (scl_rise && bit_cnt_reg != 4'h8)
                    begin
                        shift_reg <= {shift_reg[6:0], sda_s};
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    end
                    else if (scl_fall && bit_cnt_reg == 4'h8)
                    begin
                        bit_cnt_reg <= 4'h0;
                        if (state_reg == ST_ADDR)
                        begin
                            if (shift_reg[7:1] == `ICR_DEV_ADDR)
                            begin
                                reading_reg <= shift_reg[0];
                                sda_oe <= 1'b1;
                                state_reg <= ST_ACK;
                            end
                            else
                                state_reg <= ST_IDLE;
                        end
                        else
                        begin
                            sda_oe <= 1'b1;
                            state_reg <= ST_ACK;
                            if (!ptr_loaded_reg)
                            begin
                                ptr_reg <= shift_reg[4:0];
                                ptr_loaded_reg <= 1'b1;
                            end
                            else
                                ptr_reg <= ptr_reg + 5'h01;
                        end
                    end
                end
                ST_ACK:
                begin
                    if (scl_fall)
                    begin
                        if (reading_reg)
                        begin
                            state_reg <= ST_RTX;
                            shift_reg <= {rd_data[6:0], 1'b0};
                            sda_oe <= !rd_data[7];
                            bit_cnt_reg <= 4'h1;
                        end
                        else
                        begin
                            state_reg <= ST_WRX;
                            sda_oe <= 1'b0;
                            if (!ptr_loaded_reg || state_reg == ST_ACK)
                                ptr_loaded_reg <= ptr_loaded_reg;
                        end
                    end
                end
                ST_RTX:
                begin
                    if (scl_fall)
                    begin
                        if (bit_cnt_reg == 4'h8)
                        begin
                            sda_oe <= 1'b0;
                            state_reg <= ST_RACK;
                        end
                        else
                        begin
                            sda_oe <= !shift_reg[7];
                            shift_reg <= {shift_reg[6:0], 1'b0};
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        end
                    end
                end
                ST_RACK:
                begin
                    if (scl_rise)
                    begin
                        if (sda_s)
                            state_reg <= ST_IDLE;
                        else
                        begin
                            ptr_reg <= ptr_reg + 5'h01;
                            state_reg <= ST_ACK;
                        end
                    end
                end
                default:
                begin
                    sda_oe <= 1'b0;
                    ptr_loaded_reg <= 1'b0;
                end
            endcase
            if (state_reg == ST_ADDR && start_det == 1'b0 && bit_cnt_reg == 4'h0
                && !scl_s)
                ptr_loaded_reg <= ptr_loaded_reg;
        end
    end

    // ----------------------------------------
    // Register file
    // ----------------------------------------
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            source_regulation_target <= `ICR_RST_SRC;
            low_battery_limit <= `ICR_RST_LOWB;
            full_battery_limit <= `ICR_RST_FULLB;
            cold_limit <= `ICR_RST_COLD;
            hot_limit <= `ICR_RST_HOT;
            power_options <= `ICR_RST_PWR;
            doze_control <= `ICR_RST_DOZE;
            battery_adc_rate <= `ICR_RST_ADC;
            power_meter_control <= `ICR_RST_METER;
            event_enables <= `ICR_RST_EN;
            commit_reg <= 1'b0;
            sync_cnt_reg <= 4'h0;
        end
        else
        begin
            if (sync_cnt_reg != 4'h0)
                sync_cnt_reg <= sync_cnt_reg - 4'h1;
            if (wr_strobe)
            begin
                case (ptr_reg)
                    `ICR_ADDR_SRC: source_regulation_target <= shift_reg[6:0];
                    `ICR_ADDR_LOWB: low_battery_limit <= shift_reg[5:0];
                    `ICR_ADDR_FULLB: full_battery_limit <= shift_reg[5:0];
                    `ICR_ADDR_COLD: cold_limit <= shift_reg;
                    `ICR_ADDR_HOT: hot_limit <= shift_reg;
                    `ICR_ADDR_PWR: power_options <= shift_reg[3:0];
                    `ICR_ADDR_DOZE: doze_control <= shift_reg[3:0];
                    `ICR_ADDR_ADC: battery_adc_rate <= shift_reg[2:0];
                    `ICR_ADDR_METER: power_meter_control <= shift_reg[3:0];
                    `ICR_ADDR_EN: event_enables <= shift_reg[5:0];
                    `ICR_ADDR_CTRL:
                    begin
                        commit_reg <= shift_reg[`ICR_BIT_COMMIT];
                        sync_cnt_reg <= `ICR_SYNC_BUSY_CYCLES;
                    end
                    default: commit_reg <= commit_reg;
                endcase
            end
        end
    end

    // ----------------------------------------
    // Status and events
    // ----------------------------------------
    // Flags are sticky with no clear path; only reset returns them to zero
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            event_flags <= 6'h00;
            ready_seen_reg <= 1'b0;
            use_registers <= 1'b0;
            source_low <= 1'b0;
            sleep_req <= 1'b0;
            irq <= 1'b0;
        end
        else
        begin
            ready_seen_reg <= 1'b1;
            event_flags <= event_flags | event_pulse
                | {5'h00, !ready_seen_reg};
            use_registers <= commit_reg;
            source_low <= source_regulation_target < `ICR_SRC_LOW_LIMIT;
            sleep_req <= (source_regulation_target == `ICR_SRC_SLEEP_CODE)
                && doze_control[0];
            irq <= |(event_flags & event_enables);
        end
    end
endmodule
`default_nettype wire

// ### icr_master_model.sv
// Behavioural I2C bus master that drives SCL directly and SDA through an open-drain line
`timescale 1ns/1ps
`default_nettype none
module icr_master_model (
    input wire logic clk,
    input wire logic sda_line,
    output logic scl,
    output logic sda_pull
);
    // Quarter of the 160 ns bus clock, in system clock cycles
    localparam int QTR = 5;
    initial
    begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    task automatic wait_q();
        repeat (QTR) @(posedge clk);
    endtask
    // Data moves only while SCL is low, so no false start or stop is made
    task automatic bit_xfer(input logic b, output logic r);
        wait_q();
        sda_pull <= ~b;
        wait_q();
        scl <= 1'b1;
        wait_q();
        r = sda_line;
        wait_q();
        scl <= 1'b0;
    endtask
    // Serves as repeated start too: SDA is released while SCL is low first
    task automatic start();
        wait_q();
        sda_pull <= 1'b0;
        wait_q();
        scl <= 1'b1;
        wait_q();
        sda_pull <= 1'b1;
        wait_q();
        scl <= 1'b0;
    endtask
    task automatic stop();
        wait_q();
        sda_pull <= 1'b1;
        wait_q();
        scl <= 1'b1;
        wait_q();
        sda_pull <= 1'b0;
        wait_q();
    endtask
    task automatic send(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_xfer(b[i], r);
        bit_xfer(1'b1, ack);
    endtask
    task automatic recv(input logic last, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_xfer(1'b1, b[i]);
        bit_xfer(last, r);
    endtask
endmodule
`default_nettype wire

// ### icr_target_properties.sv
// Concurrent checks on the ports of the I2C configuration target
`timescale 1ns/1ps
`default_nettype none
module icr_target_chk (
    input wire clk,
    input wire rst_n,
    input wire scl_in,
    input wire sda_out,
    input wire sda_oe,
    input wire [5:0] event_pulse,
    input wire source_low,
    input wire sleep_req,
    input wire [6:0] source_regulation_target,
    input wire [5:0] low_battery_limit,
    input wire [5:0] full_battery_limit,
    input wire [3:0] doze_control,
    input wire [5:0] event_enables,
    input wire [5:0] event_flags,
    input wire irq
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    a_pull_only: assert property (sda_oe |-> !sda_out)
        else $error("SDA driven high");
    a_oe_scl_low: assert property ((sda_oe != $past(sda_oe)) |-> !scl_in)
        else $error("SDA moved while SCL high");
    a_oe_release: assert property ($rose(sda_oe) |-> ##[1:250] !sda_oe)
        else $error("SDA held low too long");
    a_src_low: assert property ($stable(source_regulation_target)[*3] |->
        source_low == (source_regulation_target < 7'h0D)) else $error("source low wrong");
    a_sleep_code: assert property ($stable({source_regulation_target, doze_control})[*3] |->
        sleep_req == (source_regulation_target == 7'h0C && doze_control[0]))
        else $error("sleep request wrong");
    a_flag_sticky: assert property ($past(rst_n) |->
        (event_flags & $past(event_flags)) == $past(event_flags)) else $error("flag lost");
    a_flag_set: assert property (event_pulse[1] |-> ##[1:3] event_flags[1])
        else $error("flag not set");
    a_irq_off: assert property (((event_flags & event_enables) == 6'h00)[*3] |-> !irq)
        else $error("irq without enabled flag");
    a_irq_on: assert property (((event_flags & event_enables) != 6'h00)[*3] |-> irq)
        else $error("irq missing");
    a_reset_vals: assert property ($rose(rst_n) |-> source_regulation_target == 7'h77 &&
        low_battery_limit == 6'h2D && full_battery_limit == 6'h33 && event_flags == 6'h00)
        else $error("reset value wrong");
    cover property ($rose(sda_oe));
    cover property (event_pulse[1]);
    cover property ($rose(sleep_req));
    cover property ($fell(irq));
endmodule
bind icr_target icr_target_chk u_chk (
    .clk(clk), .rst_n(rst_n), .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .event_pulse(event_pulse), .source_low(source_low), .sleep_req(sleep_req),
    .source_regulation_target(source_regulation_target), .low_battery_limit(low_battery_limit),
    .full_battery_limit(full_battery_limit), .doze_control(doze_control),
    .event_enables(event_enables), .event_flags(event_flags), .irq(irq)
);
`default_nettype wire

// ### tb.sv
// Testbench for the I2C configuration target
`timescale 1ns/1ps
`default_nettype none
`include "icr_map.vh"
module tb;
    logic clk;
    logic rst_n;
    logic [5:0] event_pulse;
    logic sda_out, sda_oe, use_registers, source_low, sleep_req, irq;
    logic [6:0] source_regulation_target;
    logic [5:0] low_battery_limit, full_battery_limit, event_enables, event_flags;
    logic [7:0] cold_limit, hot_limit;
    logic [3:0] power_options, doze_control, power_meter_control;
    logic [2:0] battery_adc_rate;
    logic [7:0] live_in;
    logic scl, m_pull, k;
    wire sda_line;
    logic [7:0] rbuf [0:19];
    int failures = 0;
    int n_compared = 0;
    localparam logic [7:0] DEF_TABLE [0:19] = '{8'h35, 8'h77, 8'h2D, 8'h33, 8'h8F, 8'h2F,
        8'h07, 8'h01, 8'h00, 8'h00, 8'h01, 8'h00, 8'h01, 8'hDE, 8'h5A, 8'h5A, 8'h5A, 8'h9A,
        8'hBC, 8'h00};
    // Pull-up: the line is low only while some party pulls it
    assign sda_line = ~m_pull & ~(sda_oe & ~sda_out);
    // Revision nibbles are arbitrary
    icr_target #(.REV_MAJOR(4'h3), .REV_MINOR(4'h5)) u_dut (
        .clk(clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
        .sda_oe(sda_oe), .event_pulse(event_pulse), .live_in(live_in), .meter_in(24'h5A5A5A),
        .therm_in(8'h9A), .batt_in(8'hBC), .use_registers(use_registers),
        .source_low(source_low), .sleep_req(sleep_req),
        .source_regulation_target(source_regulation_target),
        .low_battery_limit(low_battery_limit), .full_battery_limit(full_battery_limit),
        .cold_limit(cold_limit), .hot_limit(hot_limit), .power_options(power_options),
        .doze_control(doze_control), .battery_adc_rate(battery_adc_rate),
        .power_meter_control(power_meter_control), .event_enables(event_enables),
        .event_flags(event_flags), .irq(irq)
    );
    icr_master_model m (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_pull(m_pull));
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            failures++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic do_reset();
        rst_n <= 1'b0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (8) @(posedge clk);
    endtask
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d0, input logic [7:0] d1,
        input int n);
        logic ak;
        m.start();
        m.send({`ICR_DEV_ADDR, 1'b0}, ak);
        chk({7'h00, ak}, 8'h00);
        m.send(a, ak);
        m.send(d0, ak);
        if (n > 1)
            m.send(d1, ak);
        chk({7'h00, ak}, 8'h00);
        m.stop();
    endtask
    task automatic reg_read(input logic [7:0] a, input int n);
        logic ak;
        m.start();
        m.send({`ICR_DEV_ADDR, 1'b0}, ak);
        m.send(a, ak);
        m.start();
        m.send({`ICR_DEV_ADDR, 1'b1}, ak);
        chk({7'h00, ak}, 8'h00);
        for (int i = 0; i < n; i++)
            m.recv(i == n - 1, rbuf[i]);
        m.stop();
    endtask
    initial
    begin
        repeat (60000) @(posedge clk);
        failures++;
        stop_test();
    end
    initial
    begin
        rst_n = 1'b0;
        event_pulse = 6'h00;
        live_in = 8'h96;
        do_reset();
        m.start();
        m.send(8'h80, k);
        chk({7'h00, k}, 8'h01);
        m.stop();
        reg_write(8'h01, 8'hFF, 8'hFF, 2);
        reg_read(8'h01, 2);
        chk(rbuf[0], 8'h7F);
        chk(rbuf[1], 8'h3F);
        chk({2'b00, low_battery_limit}, 8'h3F);
        reg_write(8'h00, 8'hFF, 8'hFF, 1);
        reg_write(8'h12, 8'hFF, 8'hFF, 2);
        reg_read(8'h00, 1);
        chk(rbuf[0], 8'h35);
        reg_read(8'h12, 2);
        chk(rbuf[0], 8'hBC);
        chk(rbuf[1], 8'h00);
        reg_read(8'h0D, 1);
        chk(rbuf[0], 8'h96);
        live_in <= 8'hDE;
        reg_write(8'h01, 8'h0C, 8'h00, 1);
        chk({6'h00, source_low, sleep_req}, 8'h03);
        reg_write(8'h07, 8'h00, 8'h00, 1);
        chk({6'h00, source_low, sleep_req}, 8'h02);
        reg_write(8'h01, 8'h0D, 8'h00, 1);
        chk({6'h00, source_low, sleep_req}, 8'h00);
        reg_write(8'h0B, 8'hFF, 8'h00, 1);
        chk({7'h00, use_registers}, 8'h01);
        reg_read(8'h0B, 1);
        chk(rbuf[0], 8'h01);
        reg_write(8'h0B, 8'h00, 8'h00, 1);
        chk({7'h00, use_registers}, 8'h00);
        reg_write(8'h09, 8'h03, 8'h00, 2);
        chk({7'h00, irq}, 8'h00);
        @(posedge clk);
        event_pulse <= 6'h02;
        @(posedge clk);
        event_pulse <= 6'h00;
        reg_read(8'h09, 4);
        chk(rbuf[0], 8'h03);
        chk(rbuf[3], 8'h03);
        reg_write(8'h0C, 8'h00, 8'h00, 1);
        reg_write(8'h0A, 8'h02, 8'h00, 1);
        chk({2'b00, event_flags}, 8'h03);
        chk({7'h00, irq}, 8'h01);
        reg_write(8'h04, 8'hA5, 8'h5A, 2);
        chk(cold_limit, 8'hA5);
        chk(hot_limit, 8'h5A);
        do_reset();
        reg_read(8'h00, 20);
        for (int i = 0; i < 20; i++)
            chk(rbuf[i], DEF_TABLE[i]);
        chk(cold_limit, 8'h8F);
        chk(hot_limit, 8'h2F);
        chk({power_options, doze_control}, 8'h71);
        chk({battery_adc_rate, 1'b0, power_meter_control}, 8'h00);
        chk({2'b00, event_enables}, 8'h01);
        stop_test();
    end
endmodule
`default_nettype wire
